// File: rtl/cca_top.sv
// counter array top: shared time base, flags, interrupt and register slave
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1: time base advances at clock/6, clock/2, timer overflow or external input.
// R2: one 16-bit counter feeds two compare/capture modules.
// R3: module events and overflow share one interrupt request.
// R4: pins not driven by the array stay free for general use.
// R5: idle-stop bit set and idle mode active stops the counter.
// R6: counter advances only while the run bit is set.
// R7: overflow sets the overflow flag; interrupt only if enabled.
// R8: overflow flag is cleared only by a processor write.
// R9: each module has an event flag set by match or capture.
// R10: capture on rising, falling or both edges of module input.
// R11: modules also do software timer, fast toggle output and 8-bit PWM.
// R12: module event flag interrupts only while its enable bit is set.
// R13: modulation-enable bit selects pulse width modulation mode when the compare-enable bit is also set.
// R14: toggle bit inverts module output on each compare match.
// R15: match bit sets the event flag on each compare match.
// R16: falling and rising capture bits choose the capture edges.
// R17: compare-enable bit turns the comparator on; clear means no match.
// R18: PWM output low while low byte below compare; reload on wrap.
// R19: source field 00 /6, 01 /2, 10 timer, 11 external below clock/4.
// R20: on a capture edge the counter is copied into capture bytes.
// R21: software sets compare-enable and match for a software timer.
// R22: external and capture inputs are synchronised and edge-detected.
// R23: after reset counter stopped at zero, flags clear, modules off.
module cca_top
  import cca_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        idle_mode,
  input  wire logic        timer_overflow,
  input  wire logic        external_count_input,
  input  wire logic        module0_pin_in,
  output logic             module0_pin_out,
  output logic             module0_pin_oe_n,
  input  wire logic        module1_pin_in,
  output logic             module1_pin_out,
  output logic             module1_pin_oe_n,
  output logic             counter_array_irq
);
  import cca_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  logic [7:0]  aw_addr_ff;
  logic        aw_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        w_full_ff;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;

  logic [7:0]  counter_mode_register_ff;
  logic        run_control_ff;
  logic        overflow_flag_ff;
  logic [1:0]  event_flag_ff;
  logic [7:0]  mmode_ff [2];
  logic [15:0] cnt_ff;
  logic        cnt_new_ff;
  logic [2:0]  presc_ff;
  logic        div2_ff;
  logic [2:0]  ext_sync_ff;
  logic        ext_lvl_ff;
  logic        ext_fall;
  logic        tick;
  logic        adv;
  logic        ovf_evt;
  logic        cnt_wr;
  logic        ctrl_wr;
  logic [31:0] cnt_merge;
  logic [31:0] ctrl_merge;

  logic [15:0] cmp    [2];
  logic [1:0]  evt;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe_n;
  logic [1:0]  cmp_wr;

  // write channel: address and data taken in either order
  assign wr_fire = aw_full_ff && w_full_ff && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_ff    <= 8'h00;
      aw_full_ff    <= 1'b0;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      w_full_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (!aw_full_ff && !s_axi_bvalid && !s_axi_awready)
        s_axi_awready <= 1'b1;
      if (!w_full_ff && !s_axi_bvalid && !s_axi_wready)
        s_axi_wready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_ff    <= s_axi_awaddr;
        aw_full_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        w_full_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_ff   <= 1'b0;
        w_full_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    case (aw_addr_ff)
      ADDR_MODE, ADDR_CTRL, ADDR_CNT, ADDR_MMODE0,
      ADDR_MMODE1, ADDR_CMP0, ADDR_CMP1: wr_hit = 1'b1;
      default:                           wr_hit = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_MODE:   rd_val = {24'h00_0000, counter_mode_register_ff};
      ADDR_CTRL:   rd_val = {24'h00_0000, overflow_flag_ff, run_control_ff,
                             4'h0, event_flag_ff};
      ADDR_CNT:    rd_val = {16'h0000, cnt_ff};
      ADDR_MMODE0: rd_val = {24'h00_0000, mmode_ff[0]};
      ADDR_MMODE1: rd_val = {24'h00_0000, mmode_ff[1]};
      ADDR_CMP0:   rd_val = {16'h0000, cmp[0]};
      ADDR_CMP1:   rd_val = {16'h0000, cmp[1]};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      if (!s_axi_rvalid && !s_axi_arready)
        s_axi_arready <= 1'b1;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign cnt_wr     = wr_fire && (aw_addr_ff == ADDR_CNT);
  assign ctrl_wr    = wr_fire && (aw_addr_ff == ADDR_CTRL) && w_strb_ff[0];
  assign cnt_merge  = merge({16'h0000, cnt_ff}, w_data_ff, w_strb_ff);
  assign ctrl_merge = merge({24'h00_0000, overflow_flag_ff, run_control_ff,
                             4'h0, event_flag_ff}, w_data_ff, w_strb_ff);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      counter_mode_register_ff <= RST_MODE; // R23
      mmode_ff[0]              <= RST_MMODE;
      mmode_ff[1]              <= RST_MMODE;
    end
    else if (wr_fire && w_strb_ff[0])
    begin
      if (aw_addr_ff == ADDR_MODE)
        counter_mode_register_ff <= w_data_ff[7:0] & MODE_WMASK;
      if (aw_addr_ff == ADDR_MMODE0)
        mmode_ff[0] <= w_data_ff[7:0] & MMODE_WMASK;
      if (aw_addr_ff == ADDR_MMODE1)
        mmode_ff[1] <= w_data_ff[7:0] & MMODE_WMASK;
    end
  end

  // external count input: a falling change counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync_ff <= 3'h0;
      ext_lvl_ff  <= 1'b0;
    end
    else
    begin
      ext_sync_ff <= {ext_sync_ff[1:0], external_count_input}; // R22
      if (ext_sync_ff[1] == ext_sync_ff[2])
        ext_lvl_ff <= ext_sync_ff[2];
    end
  end

  // counts on falling edges; needs two stable samples per level, hence clock/4 max
  assign ext_fall = (ext_sync_ff[1] == ext_sync_ff[2]) && !ext_sync_ff[2]
                    && ext_lvl_ff; // R19

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_ff <= 3'h0;
      div2_ff  <= 1'b0;
    end
    else
    begin
      presc_ff <= (presc_ff == PRESC_LAST) ? 3'h0 : presc_ff + 3'h1;
      div2_ff  <= !div2_ff;
    end
  end

  always_comb
  begin
    case (counter_mode_register_ff[MODE_SRC_LSB +: 2]) // R1 R19
      SRC_DIV6:  tick = (presc_ff == PRESC_LAST);
      SRC_DIV2:  tick = div2_ff;
      SRC_TIMER: tick = timer_overflow;
      SRC_EXT:   tick = ext_fall;
      default:   tick = 1'b0;
    endcase
  end

  assign adv = tick && run_control_ff // R6
               && !(counter_mode_register_ff[MODE_IDLE_BIT] && idle_mode); // R5
  assign ovf_evt = adv && (cnt_ff == 16'hFFFF);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff     <= RST_CNT; // R23
      cnt_new_ff <= 1'b0;
    end
    else
    begin
      if (cnt_wr)
        cnt_ff <= cnt_merge[15:0];
      else if (adv)
        cnt_ff <= cnt_ff + 16'h0001; // R2
      cnt_new_ff <= adv && !cnt_wr;
    end
  end

  // a hardware event in the same cycle as a clearing write still sets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_control_ff   <= 1'b0; // R23
      overflow_flag_ff <= 1'b0;
      event_flag_ff    <= 2'h0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        run_control_ff   <= ctrl_merge[CTRL_RUN_BIT];
        overflow_flag_ff <= ctrl_merge[CTRL_OVF_BIT] || ovf_evt; // R8
        event_flag_ff    <= ctrl_merge[CTRL_EVT_LSB +: 2] | evt; // R9
      end
      else
      begin
        overflow_flag_ff <= overflow_flag_ff || ovf_evt; // R7
        event_flag_ff    <= event_flag_ff | evt;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter_array_irq <= 1'b0;
    else
      counter_array_irq <= (overflow_flag_ff
                            && counter_mode_register_ff[MODE_OVFIE_BIT]) // R7
                           || (event_flag_ff[0] && mmode_ff[0][MM_MODULE_EVENT_INTERRUPT_ENABLE_BIT]) // R12
                           || (event_flag_ff[1] && mmode_ff[1][MM_MODULE_EVENT_INTERRUPT_ENABLE_BIT]); // R3
  end

  assign pin_in = {module1_pin_in, module0_pin_in};
  assign cmp_wr[0] = wr_fire && (aw_addr_ff == ADDR_CMP0);
  assign cmp_wr[1] = wr_fire && (aw_addr_ff == ADDR_CMP1);

  for (genvar n = 0; n < 2; n++)
  begin : g_unit
    logic [31:0] cmp_merge;
    assign cmp_merge = merge({16'h0000, cmp[n]}, w_data_ff, w_strb_ff);
    cca_unit u_unit (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .mode        (mmode_ff[n]),
      .cnt         (cnt_ff),
      .cnt_new     (cnt_new_ff),
      .wr_en       (cmp_wr[n]),
      .wr_data     (cmp_merge[15:0]),
      .pin_in      (pin_in[n]),
      .cmp_ff      (cmp[n]),
      .event_ff    (evt[n]),
      .pin_out_ff  (pin_out[n]),
      .pin_oe_n_ff (pin_oe_n[n])
    );
  end

  assign module0_pin_out  = pin_out[0];
  assign module0_pin_oe_n = pin_oe_n[0];
  assign module1_pin_out  = pin_out[1];
  assign module1_pin_oe_n = pin_oe_n[1];
endmodule

// File: rtl/cca_unit.sv
// package and one compare/capture module of the counter array
`timescale 1ns/1ps
package cca_pkg;
  localparam logic [7:0]  ADDR_MODE      = 8'h00;
  localparam logic [7:0]  ADDR_CTRL      = 8'h04;
  localparam logic [7:0]  ADDR_CNT       = 8'h08;
  localparam logic [7:0]  ADDR_MMODE0    = 8'h0C;
  localparam logic [7:0]  ADDR_MMODE1    = 8'h10;
  localparam logic [7:0]  ADDR_CMP0      = 8'h14;
  localparam logic [7:0]  ADDR_CMP1      = 8'h18;
  localparam int          MODE_IDLE_BIT  = 7;
  localparam int          MODE_SRC_LSB   = 1;
  localparam int          MODE_OVFIE_BIT = 0;
  localparam int          CTRL_OVF_BIT   = 7;
  localparam int          CTRL_RUN_BIT   = 6;
  localparam int          CTRL_EVT_LSB   = 0;
  localparam int          MM_COMPARE_ENABLE_BIT    = 6;
  localparam int          MM_RISING_EDGE_CAPTURE_BIT    = 5;
  localparam int          MM_FALLING_EDGE_CAPTURE_BIT    = 4;
  localparam int          MM_MAT_BIT     = 3;
  localparam int          MM_TOG_BIT     = 2;
  localparam int          MM_PWM_BIT     = 1;
  localparam int          MM_MODULE_EVENT_INTERRUPT_ENABLE_BIT    = 0;
  localparam logic [7:0]  MODE_WMASK     = 8'h87;
  localparam logic [7:0]  MMODE_WMASK    = 8'h7F;
  localparam logic [7:0]  RST_MODE       = 8'h00;
  localparam logic [7:0]  RST_MMODE      = 8'h00;
  localparam logic [15:0] RST_CNT        = 16'h0000;
  localparam logic [15:0] RST_CMP        = 16'h0000;
  localparam logic [1:0]  SRC_DIV6       = 2'h0;
  localparam logic [1:0]  SRC_DIV2       = 2'h1;
  localparam logic [1:0]  SRC_TIMER      = 2'h2;
  localparam logic [1:0]  SRC_EXT        = 2'h3;
  localparam logic [2:0]  PRESC_LAST     = 3'h5;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

module cca_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  mode,
  input  wire logic [15:0] cnt,
  input  wire logic        cnt_new,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        pin_in,
  output logic      [15:0] cmp_ff,
  output logic             event_ff,
  output logic             pin_out_ff,
  output logic             pin_oe_n_ff
);
  import cca_pkg::*;

  logic [2:0] sync_ff;
  logic       lvl_ff;
  logic       chg;
  logic       cap;
  logic       match;
  logic       pwm_on;

  // sync_ff[0] is only read by sync_ff[1]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_ff <= 3'h0;
      lvl_ff  <= 1'b0;
    end
    else
    begin
      sync_ff <= {sync_ff[1:0], pin_in}; // R22
      if (sync_ff[1] == sync_ff[2])
        lvl_ff <= sync_ff[2];
    end
  end

  assign chg    = (sync_ff[1] == sync_ff[2]) && (sync_ff[2] != lvl_ff);
  assign cap    = chg && ((sync_ff[2] && mode[MM_RISING_EDGE_CAPTURE_BIT]) ||
                  (!sync_ff[2] && mode[MM_FALLING_EDGE_CAPTURE_BIT])); // R10 R16
  // compare only on a fresh counter value so a slow count matches once
  assign match  = mode[MM_COMPARE_ENABLE_BIT] && cnt_new && (cnt == cmp_ff); // R17
  assign pwm_on = mode[MM_PWM_BIT] && mode[MM_COMPARE_ENABLE_BIT]; // R13

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_ff <= RST_CMP;
    else if (wr_en)
      cmp_ff <= wr_data;
    else if (cap)
      cmp_ff <= cnt; // R20
    else if (pwm_on && cnt_new && (cnt[7:0] == 8'h00))
      cmp_ff[7:0] <= cmp_ff[15:8]; // R18
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_ff <= 1'b0;
    else
      event_ff <= cap || (match && mode[MM_MAT_BIT]); // R9 R15 R11
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out_ff  <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end
    else
    begin
      if (pwm_on)
        pin_out_ff <= !(cnt[7:0] < cmp_ff[7:0]); // R18
      else if (match && mode[MM_TOG_BIT])
        pin_out_ff <= !pin_out_ff; // R14
      // pin stays free for general use unless an output mode drives it
      pin_oe_n_ff <= !(pwm_on || mode[MM_TOG_BIT]); // R4
    end
  end
endmodule

// File: tb/cca_pin_model.sv
// pin-side partner: external count input and capture pin
`timescale 1ns/1ps
module cca_pin_model (
  input  wire logic aclk,
  output logic      ext_cnt,
  output logic      cap0
);
  initial
  begin
    ext_cnt = 1'b1;
    cap0 = 1'b0;
  end
  // edges four clocks apart keep well under the clock/4 limit
  task automatic ext_fall(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      ext_cnt <= 1'b0;
      repeat (4) @(posedge aclk);
      ext_cnt <= 1'b1;
    end
  endtask
  task automatic set_cap(input logic v);
    @(posedge aclk);
    cap0 <= v;
  endtask
endmodule

// File: tb/cca_tb_top.sv
// self-checking bench for the counter array top
`timescale 1ns/1ps
module cca_tb_top;
  import cca_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, idle_mode, timer_overflow, external_count_input;
  logic        module0_pin_in, module0_pin_out, module0_pin_oe_n, module1_pin_in;
  logic        module1_pin_out, module1_pin_oe_n, counter_array_irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  mtab [3] = '{8'h49, 8'h48, 8'h09};
  logic [7:0]  ctab [3] = '{8'h21, 8'h11, 8'h31};
  int          failures, n_checks;

  cca_top i_dut (.*);
  cca_pin_model i_pins (
    .aclk    (aclk),
    .ext_cnt (external_count_input),
    .cap0    (module0_pin_in)
  );

  always #2 aclk = ~aclk;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic fail(input string nm, input logic [15:0] e, input logic [15:0] g);
    failures++;
    $display("[FAIL] %s expected %h seen %h", nm, e, g);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
      fail(nm, e, g);
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
      fail(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic chkr(input string nm, input int lo, input int hi, input logic [15:0] g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
      fail(nm, lo[15:0], g);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
    rdr(a);
    chk(nm, e, rd[15:0]);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic start(input logic [7:0] m, input logic [15:0] c);
    wr(ADDR_MODE, {8'h00, m});
    wr(ADDR_CNT, c);
    wr(ADDR_CTRL, 16'h0040);
  endtask
  // keeps the flags that were set while running
  task automatic stop();
    rdr(ADDR_CTRL);
    wr(ADDR_CTRL, rd[15:0] & 16'h00BF);
  endtask
  task automatic cap(input logic v, input logic hit);
    wr(ADDR_CMP0, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    i_pins.set_cap(v);
    wt(8);
    rdr(ADDR_CTRL);
    chkb("cap_flag", hit, rd[0]);
    rc("cap_val", ADDR_CMP0, hit ? 16'h1234 : 16'h0000);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    final_report;
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {idle_mode, timer_overflow, module1_pin_in} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", ADDR_CTRL, 16'h0000);
    rc("cnt", ADDR_CNT, 16'h0000);
    rc("mmode0", ADDR_MMODE0, 16'h0000);
    chkb("oe_n0", 1'b1, module0_pin_oe_n);
    rdr(8'h1C);
    chk("resp", {14'h0000, RESP_SLVERR}, {14'h0000, rs});
    wr(8'h1C, 16'h0001);
    chk("wresp", {14'h0000, RESP_SLVERR}, {14'h0000, rs});
    wr(ADDR_MODE, 16'h00FF);
    chk("wresp_ok", {14'h0000, RESP_OKAY}, {14'h0000, rs});
    rc("mode", ADDR_MODE, 16'h0087);
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      int dv;
      dv = i ? 2 : 6;
      start({5'h00, i ? SRC_DIV2 : SRC_DIV6, 1'b0}, 16'h0000);
      wt(120);
      stop();
      rdr(ADDR_CNT);
      chkr("rate", 120 / dv - 1, 140 / dv + 1, rd[15:0]);
      wt(30);
      rc("halt", ADDR_CNT, rd[15:0]);
    end
    start({5'h00, SRC_TIMER, 1'b0}, 16'h0000);
    repeat (5)
    begin
      timer_overflow <= 1'b1;
      @(posedge aclk);
      timer_overflow <= 1'b0;
      wt(2);
    end
    stop();
    rc("tmr", ADDR_CNT, 16'h0005);
    start({5'h00, SRC_EXT, 1'b0}, 16'h0000);
    i_pins.ext_fall(4);
    wt(8);
    stop();
    rc("ext", ADDR_CNT, 16'h0004);
    $display("test sources done");
    idle_mode <= 1'b1;
    start({1'b1, 4'h0, SRC_DIV2, 1'b0}, 16'h0000);
    wt(40);
    stop();
    rc("idle", ADDR_CNT, 16'h0000);
    start({5'h00, SRC_DIV2, 1'b0}, 16'h0000);
    wt(40);
    stop();
    rdr(ADDR_CNT);
    chkr("idle_run", 19, 30, rd[15:0]);
    idle_mode <= 1'b0;
    $display("test idle done");
    start({5'h00, SRC_DIV2, 1'b1}, 16'hFFF0);
    wt(60);
    stop();
    chkb("irq", 1'b1, counter_array_irq);
    wt(50);
    rdr(ADDR_CTRL);
    chkb("ovf", 1'b1, rd[CTRL_OVF_BIT]);
    wr(ADDR_MODE, 16'h0002);
    wt(3);
    chkb("irq_off", 1'b0, counter_array_irq);
    wr(ADDR_CTRL, 16'h0000);
    rc("ovf_clr", ADDR_CTRL, 16'h0000);
    $display("test overflow done");
    for (int i = 0; i < 3; i++)
    begin
      logic [7:0] mm;
      mm = mtab[i];
      wr(ADDR_MMODE0, {8'h00, mm});
      wr(ADDR_CMP0, 16'h0010);
      start({5'h00, SRC_DIV2, 1'b0}, 16'h0000);
      wt(60);
      stop();
      chkb("m_irq", mm[MM_MODULE_EVENT_INTERRUPT_ENABLE_BIT] & mm[MM_COMPARE_ENABLE_BIT], counter_array_irq);
      rdr(ADDR_CTRL);
      chkb("m_flag", mm[MM_COMPARE_ENABLE_BIT], rd[0]);
      wr(ADDR_CTRL, 16'h0000);
    end
    wr(ADDR_MMODE0, 16'h004C);
    wr(ADDR_CMP0, 16'h0007);
    wr(ADDR_MMODE1, 16'h004C);
    wr(ADDR_CMP1, 16'h0005);
    start({5'h00, SRC_DIV2, 1'b0}, 16'h0000);
    wt(40);
    stop();
    chkb("tog_oe", 1'b0, module1_pin_oe_n);
    chkb("tog", 1'b1, module1_pin_out);
    chkb("tog0_oe", 1'b0, module0_pin_oe_n);
    chkb("tog0", 1'b1, module0_pin_out);
    $display("test match done");
    wr(ADDR_MMODE1, 16'h0042);
    wr(ADDR_CNT, 16'h00F0);
    wr(ADDR_CMP1, 16'h40F8);
    wt(4);
    chkb("pwm_lo", 1'b0, module1_pin_out);
    wr(ADDR_CNT, 16'h00FA);
    wt(4);
    chkb("pwm_hi", 1'b1, module1_pin_out);
    start({5'h00, SRC_DIV2, 1'b0}, 16'h00FA);
    wt(40);
    stop();
    wt(4);
    chkb("pwm_wrap", 1'b0, module1_pin_out);
    rc("reload", ADDR_CMP1, 16'h4040);
    $display("test pwm done");
    wr(ADDR_CNT, 16'h1234);
    for (int i = 0; i < 3; i++)
    begin
      logic [7:0] cm;
      cm = ctab[i];
      wr(ADDR_MMODE0, {8'h00, cm});
      cap(1'b1, cm[MM_RISING_EDGE_CAPTURE_BIT]);
      cap(1'b0, cm[MM_FALLING_EDGE_CAPTURE_BIT]);
    end
    $display("test capture done");
    final_report;
  end
endmodule

bind cca_top cca_top_props i_props (.*);

// File: tb/cca_top_props.sv
// concurrent checks on the counter array top ports
`timescale 1ns/1ps
module cca_top_props
  import cca_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        module0_pin_oe_n,
  input wire logic        module1_pin_out,
  input wire logic        module1_pin_oe_n,
  input wire logic        counter_array_irq
);
  wire logic wh = s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_quiet:
  assert property (disable iff (1'b0) !aresetn |=> !counter_array_irq && module0_pin_oe_n
    && module1_pin_oe_n && !s_axi_bvalid) else $error("outputs busy after reset");
  a_b_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_after_ar:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_release:
  assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not reopened");
  a_w_drop:
  assert property (wh |=> !s_axi_wready) else $error("wready stayed high");
  a_err_zero:
  assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  a_irq_hold:
  // the response rises on the edge that lands the write, whatever the channel order
  assert property ($fell(counter_array_irq) |-> $past(s_axi_bvalid))
    else $error("irq fell without a write");
  a_pin_driven:
  assert property ($changed(module1_pin_out) |-> !module1_pin_oe_n)
    else $error("pin changed while released");
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_irq: cover property ($rose(counter_array_irq));
  c_tog: cover property ($rose(module1_pin_out));
endmodule
